// ===== eeprom_pkg.sv
// Constants and types shared by the dual-mode serial EEPROM port
// How it works
// - Power-up always starts in stream mode
// - SCL falling edge locks addressed bus mode
// - Stream bytes MSB first, then null bit
// - Stream bits change on stream clock rise
// - Stream addresses advance, wrap without pause
// - Nine sync clocks released, tenth drives MSB
// - Stream start address is not defined; here it resets to address 0
// - Bus mode uses stream clock level only
// - Decode START, STOP and idle bus
// - Receiver acks low on ninth clock
// - No acknowledge while programming runs
// - Master nack ends read, device releases SDA
// - Control byte: code, three ignored, direction
// - Ack own control byte only when idle
// - Byte write: control, address, data, STOP
// - Eight byte buffer committed only at STOP
// - Only low three pointer bits advance on writes; reads step the whole pointer
package eeprom_pkg;
   // Array geometry
   localparam int ADDR_W     = 7;
   localparam int DEPTH      = 128;
   localparam int PAGE_W     = 3;
   localparam int PAGE_BYTES = 8;
   // Control byte code
   localparam logic [3:0] DEVICE_CODE = 4'ha;
   // Stream framing counts
   localparam logic [3:0] SYNC_EDGES = 4'h9;
   localparam logic [3:0] NULL_BIT   = 4'h8;
   // Values after reset
   localparam logic [ADDR_W-1:0] STREAM_ADDR_RST = 7'h00;
   localparam logic [ADDR_W-1:0] PTR_RST         = 7'h00;
   // Self-timed write cycle
   localparam int CLK_PERIOD_NS = 8;
   localparam int WRITE_TIME_MS = 10;
   localparam int WRITE_CYCLES  = WRITE_TIME_MS * 1000000 / CLK_PERIOD_NS;
   localparam int TIMER_W       = 21;
   // Two-wire slave states
   typedef enum logic [9:0] {
      S_IDLE     = 10'h001,
      S_CTRL     = 10'h002,
      S_CTRL_ACK = 10'h004,
      S_ADDR     = 10'h008,
      S_ADDR_ACK = 10'h010,
      S_DATA     = 10'h020,
      S_DATA_ACK = 10'h040,
      S_RD       = 10'h080,
      S_RD_ACK   = 10'h100,
      S_SKIP     = 10'h200
   } bus_state_type;
endpackage : eeprom_pkg

// ===== pin_sync.sv
// Three-stage synchroniser that passes a bit once stages two and three agree
`timescale 1ns/100ps
module pin_sync #(
   parameter int             W       = 1,
   parameter logic [W-1:0]   RST_VAL = '0
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // Asynchronous inputs and clean outputs
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] s1;      // Metastable stage, read by s2 only
   logic [W-1:0] s2;      // Second stage
   logic [W-1:0] s3;      // Third stage
   logic [W-1:0] next_q;  // Agreed value

   ////////////////////////////////////////
   // Take a change only when two stages agree, filtering one-cycle glitches
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         always_comb begin
            next_q[g] = (s2[g] == s3[g]) ? s3[g] : q_o[g];
         end
      end
   endgenerate

   // Stages and output register
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s1  <= RST_VAL;
         s2  <= RST_VAL;
         s3  <= RST_VAL;
         q_o <= RST_VAL;
      end else begin
         s1  <= d_i;
         s2  <= s1;
         s3  <= s2;
         q_o <= next_q;
      end
   end
endmodule : pin_sync

// ===== stream_tx.sv
// Stream-mode transmitter clocked by the stream clock pin
`timescale 1ns/100ps
module stream_tx (
   // Link clock and power-up reset
   input  wire logic                          stream_clock_in_i,
   input  wire logic                          rst_i,
   // Mode from the system domain
   input  wire logic                          bus_mode_i,
   // Array byte at the stream address
   input  wire logic [7:0]                    byte_i,
   output logic      [eeprom_pkg::ADDR_W-1:0] addr_o,
   // Pull SDA low
   output logic                               drive_low_o
);
   import eeprom_pkg::*;

   logic              bus_mode_s;  // Mode seen in this domain
   logic [3:0]        sync_cnt;    // Edges spent synchronising
   logic [3:0]        bit_cnt;     // Bit slot in byte, 8 is null
   logic [3:0]        next_sync;
   logic [3:0]        next_bit;
   logic [ADDR_W-1:0] next_addr;
   logic              next_low;

   ////////////////////////////////////////
   // Mode crossing into the link domain
   pin_sync #(.W(1), .RST_VAL(1'b0)) u_mode_sync (
      .clk_i (stream_clock_in_i),
      .rst_i (rst_i),
      .d_i   (bus_mode_i),
      .q_o   (bus_mode_s)
   );

   ////////////////////////////////////////
   // Next bit on each rising edge
   always_comb begin
      next_sync = sync_cnt;
      next_bit  = bit_cnt;
      next_addr = addr_o;
      next_low  = 1'b0;
      if (bus_mode_s) begin
         // Pin released for good once addressed
         next_low = 1'b0;
      end else if (sync_cnt != SYNC_EDGES) begin
         // Line stays released during synchronisation
         next_sync = sync_cnt + 4'h1;
      end else begin
         // Data slot or released null slot
         next_low = (bit_cnt != NULL_BIT)
                    && !byte_i[3'(4'h7 - bit_cnt)];
         if (bit_cnt == NULL_BIT) begin
            next_bit  = 4'h0;
            next_addr = addr_o + 7'h01;
         end else begin
            next_bit = bit_cnt + 4'h1;
         end
      end
   end

   // Registers; start address resets to STREAM_ADDR_RST, address 0
   always_ff @(posedge stream_clock_in_i or posedge rst_i) begin
      if (rst_i) begin
         sync_cnt    <= 4'h0;
         bit_cnt     <= 4'h0;
         addr_o      <= STREAM_ADDR_RST;
         drive_low_o <= 1'b0;
      end else begin
         sync_cnt    <= next_sync;
         bit_cnt     <= next_bit;
         addr_o      <= next_addr;
         drive_low_o <= next_low;
      end
   end

   ////////////////////////////////////////
   // Checks on the link clock
   AST_SYNC_QUIET: assert property (@(posedge stream_clock_in_i) disable iff (rst_i)
      sync_cnt != SYNC_EDGES |=> !drive_low_o)
      else $error("SDA driven during synchronisation");
   AST_NULL_SLOT: assert property (@(posedge stream_clock_in_i) disable iff (rst_i)
      (bit_cnt == NULL_BIT && sync_cnt == SYNC_EDGES && !bus_mode_s)
      |=> !drive_low_o && bit_cnt == 4'h0 && addr_o == $past(addr_o) + 7'h01)
      else $error("Null slot or address step wrong");
endmodule : stream_tx

// ===== dual_mode_serial_eeprom_port.sv
// Dual-mode serial EEPROM port: power-up stream mode and two-wire slave
`timescale 1ns/100ps
module dual_mode_serial_eeprom_port #(
   parameter int WRITE_CYCLES_P = eeprom_pkg::WRITE_CYCLES  // Busy time
) (
   // System clock and power-up reset
   input  wire logic mclk_i,
   input  wire logic rst_i,
   // Stream clock pin, write enable in bus mode
   input  wire logic stream_clock_in_i,
   // Two-wire bus pins
   input  wire logic scl_i,
   input  wire logic sda_i,
   output logic      sda_o,
   output logic      sda_oe_o,
   // Status
   output logic      bus_mode_o,
   output logic      write_busy_o
);
   import eeprom_pkg::*;

   ////////////////////////////////////////
   // Storage
   logic [7:0]          mem  [DEPTH];       // Array, no reset
   logic [7:0]          pbuf [PAGE_BYTES];  // Page buffer

   // Synchronised pins
   logic                scl_s;     // Clean SCL
   logic                sda_s;     // Clean SDA
   logic                we_s;      // Write enable level
   logic                st_low_s;  // Stream drive from link domain
   logic                scl_d;     // SCL one cycle back
   logic                sda_d;     // SDA one cycle back

   // Bus events
   logic                scl_rise;
   logic                scl_fall;
   logic                start_ev;
   logic                stop_ev;

   // Link side
   logic [ADDR_W-1:0]   s_addr;    // Stream address
   logic                s_low;     // Stream pulls low
   logic [7:0]          s_byte;    // Stream byte
   logic [7:0]          rd_byte;   // Byte at bus pointer

   // Slave state
   bus_state_type       st;
   logic                bus_mode;  // Sticky addressed bus mode
   logic [2:0]          cnt;       // Bit counter
   logic                got;       // Eight bits shifted in
   logic                rd;        // Direction of this command
   logic                macked;    // Master acked last read byte
   logic [7:0]          shreg;     // Receive shifter
   logic [7:0]          tx;        // Transmit shifter
   logic [ADDR_W-1:0]   ptr;       // Address pointer
   logic [PAGE_BYTES-1:0] pvalid;  // Buffered slots
   logic                drive;     // Slave pulls SDA low
   logic                busy;      // Programming running
   logic [TIMER_W-1:0]  timer;     // Busy countdown

   // Next values
   bus_state_type       next_st;
   logic                next_bus_mode;
   logic [2:0]          next_cnt;
   logic                next_got;
   logic                next_rd;
   logic                next_macked;
   logic [7:0]          next_shreg;
   logic [7:0]          next_tx;
   logic [ADDR_W-1:0]   next_ptr;
   logic [PAGE_BYTES-1:0] next_pvalid;
   logic                next_drive;
   logic                next_busy;
   logic [TIMER_W-1:0]  next_timer;
   logic                next_oe;
   logic                buf_we;    // Store byte in page buffer
   logic                commit;    // Copy buffer into array

   ////////////////////////////////////////
   // Pin synchronisers; SCL and SDA rest high so reset sees no edge
   pin_sync #(.W(4), .RST_VAL(4'h3)) u_pin_sync (
      .clk_i (mclk_i),
      .rst_i (rst_i),
      .d_i   ({s_low, stream_clock_in_i, scl_i, sda_i}),
      .q_o   ({st_low_s, we_s, scl_s, sda_s})
   );

   ////////////////////////////////////////
   // Stream transmitter on the link clock.
   // It reads the array across domains; safe because the array only
   // changes in bus mode, after the stream side has gone quiet.
   assign s_byte  = mem[s_addr];
   assign rd_byte = mem[ptr];

   stream_tx u_stream_tx (
      .stream_clock_in_i (stream_clock_in_i),
      .rst_i             (rst_i),
      .bus_mode_i        (bus_mode),
      .byte_i            (s_byte),
      .addr_o            (s_addr),
      .drive_low_o       (s_low)
   );

   ////////////////////////////////////////
   // Edge and condition decode
   assign scl_rise = !scl_d && scl_s;
   assign scl_fall = scl_d && !scl_s;
   assign start_ev = scl_d && scl_s && sda_d && !sda_s;
   assign stop_ev  = scl_d && scl_s && !sda_d && sda_s;

   // Previous pin levels
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   ////////////////////////////////////////
   // Slave state machine and write timer
   always_comb begin
      next_st     = st;
      next_cnt    = cnt;
      next_got    = got;
      next_rd     = rd;
      next_macked = macked;
      next_shreg  = shreg;
      next_tx     = tx;
      next_ptr    = ptr;
      next_pvalid = pvalid;
      next_drive  = drive;
      next_busy   = busy;
      next_timer  = timer;
      buf_we      = 1'b0;
      commit      = 1'b0;
      // Any qualified SCL fall locks bus mode until power is lost
      next_bus_mode = bus_mode || scl_fall;
      // Self-timed programming countdown
      if (busy) begin
         if (timer == TIMER_W'(1)) begin
            next_busy = 1'b0;
         end else begin
            next_timer = timer - TIMER_W'(1);
         end
      end
      if (!bus_mode) begin
         // Stream mode: slave logic stays idle
         next_st = S_IDLE;
      end else if (start_ev) begin
         // START always restarts; unfinished writes are dropped
         next_st     = S_CTRL;
         next_cnt    = 3'h0;
         next_got    = 1'b0;
         next_drive  = 1'b0;
         next_pvalid = '0;
      end else if (stop_ev) begin
         next_st     = S_IDLE;
         next_drive  = 1'b0;
         next_pvalid = '0;
         // Program only if data arrived and writes are enabled
         if (pvalid != '0 && we_s && !busy) begin
            commit     = 1'b1;
            next_busy  = 1'b1;
            next_timer = TIMER_W'(WRITE_CYCLES_P);
         end
      end else begin
         case (st)
            S_CTRL, S_ADDR, S_DATA: begin
               // Sample on SCL rise, act on the fall after bit eight
               if (scl_rise && !got) begin
                  next_shreg = {shreg[6:0], sda_s};
                  next_cnt   = cnt + 3'h1;
                  next_got   = (cnt == 3'h7);
               end else if (scl_fall && got) begin
                  next_got = 1'b0;
                  if (st == S_CTRL) begin
                     // Own code and idle: ack; else stay silent
                     if (shreg[7:4] == DEVICE_CODE && !busy) begin
                        next_drive = 1'b1;
                        next_rd    = shreg[0];
                        next_st    = S_CTRL_ACK;
                     end else begin
                        next_st = S_SKIP;
                     end
                  end else if (st == S_ADDR) begin
                     next_ptr   = shreg[ADDR_W-1:0];
                     next_drive = 1'b1;
                     next_st    = S_ADDR_ACK;
                  end else begin
                     // Later bytes overwrite the oldest slot
                     buf_we                     = 1'b1;
                     next_pvalid[ptr[PAGE_W-1:0]] = 1'b1;
                     next_ptr = {ptr[ADDR_W-1:PAGE_W],
                                 ptr[PAGE_W-1:0] + 3'h1};
                     next_drive = 1'b1;
                     next_st    = S_DATA_ACK;
                  end
               end
            end
            S_CTRL_ACK: begin
               if (scl_fall) begin
                  next_cnt = 3'h0;
                  if (rd) begin
                     next_tx    = rd_byte;
                     next_drive = !rd_byte[7];
                     next_st    = S_RD;
                  end else begin
                     next_drive = 1'b0;
                     next_st    = S_ADDR;
                  end
               end
            end
            S_ADDR_ACK, S_DATA_ACK: begin
               // Release after the ack clock, then take data
               if (scl_fall) begin
                  next_drive = 1'b0;
                  next_cnt   = 3'h0;
                  next_st    = S_DATA;
               end
            end
            S_RD: begin
               // Shift out on SCL falls, MSB first
               if (scl_fall) begin
                  if (cnt == 3'h7) begin
                     next_drive = 1'b0;
                     next_ptr   = ptr + 7'h01;
                     next_st    = S_RD_ACK;
                  end else begin
                     next_tx    = {tx[6:0], 1'b0};
                     next_drive = !tx[6];
                     next_cnt   = cnt + 3'h1;
                  end
               end
            end
            S_RD_ACK: begin
               if (scl_rise) begin
                  next_macked = !sda_s;
               end else if (scl_fall) begin
                  if (macked) begin
                     next_tx    = rd_byte;
                     next_drive = !rd_byte[7];
                     next_cnt   = 3'h0;
                     next_st    = S_RD;
                  end else begin
                     // No ack: line stays released for STOP
                     next_drive = 1'b0;
                     next_st    = S_SKIP;
                  end
               end
            end
            S_IDLE, S_SKIP: begin
               // Wait for START
               next_drive = 1'b0;
            end
            default: begin
               next_st    = S_IDLE;
               next_drive = 1'b0;
            end
         endcase
      end
      // Pin follows the stream side until bus mode
      next_oe = next_bus_mode ? next_drive : st_low_s;
   end

   // State registers
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         st           <= S_IDLE;
         bus_mode     <= 1'b0;
         cnt          <= 3'h0;
         got          <= 1'b0;
         rd           <= 1'b0;
         macked       <= 1'b0;
         shreg        <= 8'h00;
         tx           <= 8'h00;
         ptr          <= PTR_RST;
         pvalid       <= '0;
         drive        <= 1'b0;
         busy         <= 1'b0;
         timer        <= '0;
         sda_o        <= 1'b0;
         sda_oe_o     <= 1'b0;
         bus_mode_o   <= 1'b0;
         write_busy_o <= 1'b0;
      end else begin
         st           <= next_st;
         bus_mode     <= next_bus_mode;
         cnt          <= next_cnt;
         got          <= next_got;
         rd           <= next_rd;
         macked       <= next_macked;
         shreg        <= next_shreg;
         tx           <= next_tx;
         ptr          <= next_ptr;
         pvalid       <= next_pvalid;
         drive        <= next_drive;
         busy         <= next_busy;
         timer        <= next_timer;
         sda_o        <= 1'b0;  // Open drain: only ever pulls low
         sda_oe_o     <= next_oe;
         bus_mode_o   <= next_bus_mode;
         write_busy_o <= next_busy;
      end
   end

   ////////////////////////////////////////
   // Page buffer and array writes; whole page lands in one cycle
   always_ff @(posedge mclk_i) begin
      if (buf_we) begin
         pbuf[ptr[PAGE_W-1:0]] <= shreg;
      end
      for (int i = 0; i < PAGE_BYTES; i++) begin
         if (commit && pvalid[i]) begin
            mem[{ptr[ADDR_W-1:PAGE_W], 3'(i)}] <= pbuf[i];
         end
      end
   end

   ////////////////////////////////////////
   // Checks on the system clock
   sequence seq_byte_in;
      got ##0 scl_fall;
   endsequence

   AST_MODE_ENTER: assert property (@(posedge mclk_i) disable iff (rst_i)
      scl_fall |=> bus_mode_o ##1 bus_mode_o)
      else $error("SCL fall did not select bus mode");
   AST_MODE_HOLD: assert property (@(posedge mclk_i) disable iff (rst_i)
      bus_mode_o |=> bus_mode_o)
      else $error("Bus mode was left");
   AST_START: assert property (@(posedge mclk_i) disable iff (rst_i)
      (bus_mode && start_ev) |=> st == S_CTRL && !sda_oe_o)
      else $error("START not decoded");
   AST_STOP: assert property (@(posedge mclk_i) disable iff (rst_i)
      (bus_mode && stop_ev && !start_ev) |=> st == S_IDLE && !sda_oe_o)
      else $error("STOP not decoded");
   AST_CTRL_ACK: assert property (@(posedge mclk_i) disable iff (rst_i)
      (st == S_CTRL && shreg[7:4] == DEVICE_CODE && !busy && !start_ev && !stop_ev)
      ##0 seq_byte_in |=> sda_oe_o && st == S_CTRL_ACK)
      else $error("Own control byte not acknowledged");
   AST_BUSY_NOACK: assert property (@(posedge mclk_i) disable iff (rst_i)
      (st == S_CTRL && busy) ##0 seq_byte_in |=> !sda_oe_o [*2])
      else $error("Acknowledged while programming");
   AST_PAGE_WRAP: assert property (@(posedge mclk_i) disable iff (rst_i)
      (st == S_DATA && !start_ev && !stop_ev) ##0 seq_byte_in
      |=> ptr[6:3] == $past(ptr[6:3]) && ptr[2:0] == $past(ptr[2:0]) + 3'h1)
      else $error("Pointer step wrong in page");
   AST_WE_GATE: assert property (@(posedge mclk_i) disable iff (rst_i)
      $rose(busy) |-> $past(we_s) && $past(stop_ev))
      else $error("Programming started without enable");
endmodule : dual_mode_serial_eeprom_port

// ===== host_model.sv
// Two-wire bus master and stream clock source facing the EEPROM port
`timescale 1ns/100ps
module host_model (
   // Bus and stream pins
   output logic      scl_o,
   output logic      sda_low_o,
   output logic      stream_clock_in_o,
   // Resolved data wire
   input  wire logic sda_i
);
   // Idle bus, stream clock parked low between frames
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
      stream_clock_in_o = 1'b0;
   end
   // One stream clock pulse, 15 ns high, returning as it falls
   task automatic stream_clock_in_cycle();
      stream_clock_in_o = 1'b1;
      #15;
      stream_clock_in_o = 1'b0;
   endtask : stream_clock_in_cycle
   // Write enable level, only meaningful in bus mode
   task automatic set_we(input logic v);
      stream_clock_in_o = v;
   endtask : set_we
   // One SCL pulse to leave stream mode
   task automatic wake();
      scl_o = 1'b0;
      #200;
      scl_o = 1'b1;
      #200;
   endtask : wake
   // START from an idle bus
   task automatic start_c();
      sda_low_o = 1'b1;
      #80;
      scl_o = 1'b0;
      #40;
   endtask : start_c
   // STOP, entered with SCL low
   task automatic stop_c();
      sda_low_o = 1'b1;
      #40;
      scl_o = 1'b1;
      #80;
      sda_low_o = 1'b0;
      #80;
   endtask : stop_c
   // Eight data clocks, then the acknowledge clock
   task automatic send_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         sda_low_o = ~b[i];
         #40;
         scl_o = 1'b1;
         #80;
         scl_o = 1'b0;
         #40;
      end
      // Release so only the slave can pull low
      sda_low_o = 1'b0;
      #40;
      scl_o = 1'b1;
      #60;
      ack = ~sda_i;
      #20;
      scl_o = 1'b0;
      #40;
   endtask : send_byte
   // Eight clocks read from the slave, then the master's own ack clock
   task automatic recv_byte(input logic ack_it, output logic [7:0] b);
      sda_low_o = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         #40;
         scl_o = 1'b1;
         #60;
         b[i] = sda_i;
         #20;
         scl_o = 1'b0;
         #40;
      end
      // Low asks for the next byte, released ends the read
      sda_low_o = ack_it;
      #40;
      scl_o = 1'b1;
      #80;
      scl_o = 1'b0;
      #40;
      sda_low_o = 1'b0;
   endtask : recv_byte
endmodule : host_model

// ===== tb_top.sv
// Bench: bus writes, power cycle, then the stream read back
`timescale 1ns/100ps
module tb_top;
   // Clock, reset and pins
   logic mclk_i, rst_i, scl, sda_low, stream_clock_in, sda_o, sda_oe_o, bus_mode_o, write_busy_o;
   wire  sda_w;
   int   n_fail, checks;
   logic ack;
   logic [7:0] rx;
   // Rows: expected stream bytes of addresses 0 to 15
   localparam logic [7:0] ROWS [16] = '{8'ha5, 8'h3c, 8'h0f, 8'hf0, 8'h96, 8'h69, 8'h01,
      8'h80, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19};
   // Open drain wire with pull-up
   assign sda_w = ~((sda_oe_o & ~sda_o) | sda_low);
   dual_mode_serial_eeprom_port #(.WRITE_CYCLES_P(1000)) dut_u (.mclk_i(mclk_i),
      .rst_i(rst_i), .stream_clock_in_i(stream_clock_in), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
      .sda_oe_o(sda_oe_o), .bus_mode_o(bus_mode_o), .write_busy_o(write_busy_o));
   host_model m_u (.scl_o(scl), .sda_low_o(sda_low), .stream_clock_in_o(stream_clock_in), .sda_i(sda_w));
   // 125 MHz system clock
   initial begin
      mclk_i = 1'b0;
      forever #4 mclk_i = ~mclk_i;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Compare and count
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         n_fail++;
      end
   endtask : chk
   // Byte that the slave must acknowledge
   task automatic send(input logic [7:0] b);
      m_u.send_byte(b, ack);
      chk({7'h00, ack}, 8'h01);
      chk({7'h00, sda_o}, 8'h00);
   endtask : send
   // Bounded wait for the write timer to finish
   task automatic wait_idle();
      for (int i = 0; i < 2000 && write_busy_o !== 1'b0; i++) begin
         @(posedge mclk_i);
         #1;
      end
      chk({7'h00, write_busy_o}, 8'h00);
   endtask : wait_idle
   // Slot p is stream edge p+1: sync slots, 8 data bits, released null slot
   function automatic logic [7:0] exp_oe(input int p);
      if (p < 9 || (p - 9) % 9 == 8) return 8'h00;
      return {7'h00, ~ROWS[(p - 9) / 9][7 - (p - 9) % 9]};
   endfunction : exp_oe
   // Verdict
   task automatic wrap_up();
      if (n_fail == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : wrap_up
   ////////////////////////////////////////////////////////////////////////////////
   // Watchdog, well beyond the expected 68 us
   initial begin
      #300000;
      n_fail++;
      wrap_up();
   end
   // Main sequence
   initial begin
      n_fail = 0;
      checks = 0;
      rst_i = 1'b1;
      repeat (10) @(posedge mclk_i);
      #1 rst_i = 1'b0;
      repeat (5) @(posedge mclk_i);
      #1 chk({7'h00, bus_mode_o}, 8'h00);
      m_u.wake();
      chk({7'h00, bus_mode_o}, 8'h01);
      m_u.set_we(1'b1);
      // Page write of rows 0 to 7
      m_u.start_c();
      send(8'ha0);
      send(8'h00);
      for (int k = 0; k < 8; k++) send(ROWS[k]);
      m_u.stop_c();
      #200 chk({7'h00, write_busy_o}, 8'h01);
      // Own control byte while programming is refused
      m_u.start_c();
      m_u.send_byte(8'ha0, ack);
      chk({7'h00, ack}, 8'h00);
      m_u.stop_c();
      wait_idle();
      // Foreign device code gets no answer
      m_u.start_c();
      m_u.send_byte(8'h5e, ack);
      chk({7'h00, ack}, 8'h00);
      m_u.stop_c();
      // Ten bytes from 0x0e wrap inside the page of rows 8 to 15
      m_u.start_c();
      send(8'ha0);
      send(8'h0e);
      for (int k = 0; k < 10; k++) send(8'h10 + k[7:0]);
      m_u.stop_c();
      wait_idle();
      // Write enable low at STOP: nothing programmed
      m_u.set_we(1'b0);
      m_u.start_c();
      send(8'ha0);
      send(8'h00);
      send(8'hff);
      m_u.stop_c();
      #400 chk({7'h00, write_busy_o}, 8'h00);
      // Current address read from pointer 1: three acked, fourth refused
      m_u.start_c();
      send(8'ha1);
      for (int k = 1; k <= 4; k++) begin
         m_u.recv_byte(k < 4, rx);
         chk(rx, ROWS[k]);
      end
      // Next byte starts with a low bit, so a missed release would show
      #40 chk({7'h00, sda_w}, 8'h01);
      m_u.stop_c();
      // Power cycle, then read the array back as a stream
      rst_i = 1'b1;
      repeat (10) @(posedge mclk_i);
      #1 rst_i = 1'b0;
      repeat (5) @(posedge mclk_i);
      #1;
      for (int s = 0; s <= 9 + 16 * 9; s++) begin
         m_u.stream_clock_in_cycle();
         #10;
         if (s > 0) chk({7'h00, sda_oe_o}, exp_oe(s - 1));
         #5;
      end
      chk({7'h00, bus_mode_o}, 8'h00);
      wrap_up();
   end
endmodule : tb_top
